// ===== src/hbi_pkg.sv
// Purpose: Shared constants and carrier types for the host bus interface arbiter.
// Assumes: A 16-bit data path and a 22-bit byte address on the host side.
// Notes:   The register block holds 64 words and spans 128 bytes.
package hbi_pkg;
    // ============================================================
    // Widths and register block layout
    // ============================================================
    localparam int         AW          = 22;
    localparam int         DW          = 16;
    localparam int         NREGS       = 64;
    localparam int         BASE_LSB    = 7;
    localparam int         IDX_LSB     = 1;
    localparam int         IDX_MSB     = 6;
    localparam int         RELOC_SPACE = 0;
    localparam logic [5:0] REG_RELOC   = 6'h00;
    localparam logic [5:0] REG_GP_OPC  = 6'h02;
    localparam logic [5:0] REG_GP_ADR  = 6'h03;
    localparam logic [5:0] REG_DP_OPC  = 6'h04;
    localparam logic [5:0] REG_DP_ADR  = 6'h05;
    localparam logic [15:0] RELOC_RST  = 16'h0000;
    localparam logic [15:0] REG_RST    = 16'h0000;

    // ============================================================
    // Bus status encodings, active low
    // ============================================================
    localparam logic [1:0] ST_READ  = 2'h1;
    localparam logic [1:0] ST_WRITE = 2'h2;
    localparam logic [1:0] ST_IDLE  = 2'h3;

    // ============================================================
    // Types
    // ============================================================
    typedef enum logic [2:0] {
        S_IDLE = 3'b000, S_REG = 3'b001, S_GMEM = 3'b010, S_END = 3'b011,
        S_HOLD = 3'b100, S_MST = 3'b101, S_REL = 3'b110
    } hbi_state_e;
    typedef enum logic [1:0] {OWN_HOST = 2'b00, OWN_GP = 2'b01, OWN_DP = 2'b10} hbi_own_e;
    typedef struct packed {
        logic          req;
        logic          sys;
        logic          we;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } hbi_preq_s;
    typedef struct packed {
        logic          ack;
        logic [DW-1:0] rdata;
    } hbi_prsp_s;
    typedef struct packed {
        logic          go;
        logic [DW-1:0] opcode;
        logic [DW-1:0] addr;
    } hbi_cmd_s;
    typedef struct packed {
        logic          req;
        logic          we;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } hbi_mem_s;
    typedef struct packed {
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
        logic [1:0]    st_n;
        logic          rd_n;
        logic          wr_n;
        logic          oe_n;
    } hbi_mst_s;
    localparam hbi_mst_s MST_IDLE = '{addr: '0, wdata: '0, st_n: ST_IDLE,
                                      rd_n: 1'b1, wr_n: 1'b1, oe_n: 1'b1};
endpackage

// ===== src/hbi_arbiter.sv
// Purpose: Bus interface unit joining host, graphics memory and two internal processors.
// Assumes: All inputs are synchronous to REF_CLK_I; requesters hold req until ack.
// Notes:   One access is in flight at a time, so host and master accesses never overlap.
`timescale 1ns/1ns
// Contract
// - A host slave access is carried out and then finished by a ready pulse.
// - A master transfer starts by raising the hold request toward the host.
// - The system bus is driven only after the grant acknowledge has been seen.
// - After the master transfer hold drops and the device waits for the grant to drop.
// - Host, display and graphics requesters are served one at a time.
// - A DMA requester uses the same host port and handshake as the CPU.
// - Slaves reach the register block or graphics memory; masters reach system memory.
// - A host graphics memory access and a master system access never overlap.
// - In synchronous mode the host status lines are decoded directly.
// - As master in synchronous mode the device emits host-style status lines.
// - In asynchronous mode slave accesses are qualified by read and write strobes.
// - A 64-word register block is relocatable to any 128-byte boundary in I/O or memory.
// - Only the host can reach the register block, never the internal processors.
// - Reads of reserved register words give data that nobody may rely on.
// - Writing an opcode register launches a command to the matching processor.
module hbi_arbiter
    import hbi_pkg::*;
(
    input  wire logic          REF_CLK_I,
    input  wire logic          NRST_I,
    input  wire logic          SYNC_MODE_I,
    input  wire logic          HOST_CS_N_I,
    input  wire logic          HOST_MIO_I,
    input  wire logic [1:0]    HOST_ST_N_I,
    input  wire logic          HOST_RD_N_I,
    input  wire logic          HOST_WR_N_I,
    input  wire logic [AW-1:0] HOST_ADDR_I,
    input  wire logic [DW-1:0] HOST_WDATA_I,
    output logic      [DW-1:0] HOST_RDATA_O,
    output logic               HOST_READY_N_O,
    input  wire hbi_preq_s     GP_REQ_I,
    output hbi_prsp_s          GP_RSP_O,
    input  wire hbi_preq_s     DP_REQ_I,
    output hbi_prsp_s          DP_RSP_O,
    output hbi_cmd_s           GP_CMD_O,
    output hbi_cmd_s           DP_CMD_O,
    output hbi_mem_s           GMEM_O,
    input  wire logic          GMEM_ACK_I,
    input  wire logic [DW-1:0] GMEM_RDATA_I,
    output logic               HOLD_O,
    input  wire logic          BUS_GRANT_ACK_I,
    output hbi_mst_s           MST_O,
    input  wire logic          MST_READY_I,
    input  wire logic [DW-1:0] MST_RDATA_I
);
    // ============================================================
    // State
    // ============================================================
    hbi_state_e    state_r, state_nxt;
    hbi_own_e      own_r, own_nxt;
    logic          ready_n_r, ready_n_nxt;
    logic [DW-1:0] rdata_r, rdata_nxt, done_data;
    logic          hold_r, hold_nxt;
    hbi_mem_s      gmem_r, gmem_nxt;
    hbi_mst_s      mst_r, mst_nxt;
    hbi_prsp_s     gp_rsp_r, gp_rsp_nxt, dp_rsp_r, dp_rsp_nxt;
    hbi_cmd_s      gp_cmd_r, gp_cmd_nxt, dp_cmd_r, dp_cmd_nxt;
    logic [DW-1:0] regs_r [NREGS];
    logic [5:0]    wr_idx;
    logic          host_rd, host_wr, host_start, reg_hit, dp_go, gp_go, done, wr_en;
    hbi_preq_s     nr, cur;
    default clocking cb_sva @(posedge REF_CLK_I); endclocking
    default disable iff (!NRST_I);
    // Picks the request of the internal processor that owns the bus.
    function automatic hbi_preq_s sel_req(hbi_own_e own, hbi_preq_s gp, hbi_preq_s dp);
        sel_req = (own == OWN_DP) ? dp : gp;
    endfunction
    // ============================================================
    // Host decode
    // ============================================================
    // Status lines in synchronous mode, strobes otherwise; DMA uses the same port.
    assign host_rd    = SYNC_MODE_I ? (HOST_ST_N_I == ST_READ) : !HOST_RD_N_I;
    assign host_wr    = SYNC_MODE_I ? (HOST_ST_N_I == ST_WRITE) : !HOST_WR_N_I;
    assign host_start = !HOST_CS_N_I && (host_rd || host_wr);
    // Block match on the relocation base and the selected address space.
    assign reg_hit = (HOST_MIO_I == regs_r[REG_RELOC][RELOC_SPACE]) &&
                     (HOST_ADDR_I[AW-1:BASE_LSB] == regs_r[REG_RELOC][DW-1:1]);
    // A requester just acknowledged is skipped for one cycle while it drops req.
    assign dp_go = DP_REQ_I.req && !dp_rsp_r.ack;
    assign gp_go = GP_REQ_I.req && !gp_rsp_r.ack;
    // ============================================================
    // Arbiter and sequencer, next values
    // ============================================================
    always_comb begin
        state_nxt   = state_r;
        own_nxt     = own_r;
        ready_n_nxt = 1'b1;
        rdata_nxt   = rdata_r;
        hold_nxt    = hold_r;
        gmem_nxt    = gmem_r;
        mst_nxt     = mst_r;
        gp_rsp_nxt  = '{ack: 1'b0, rdata: gp_rsp_r.rdata};
        dp_rsp_nxt  = '{ack: 1'b0, rdata: dp_rsp_r.rdata};
        gp_cmd_nxt  = '{go: 1'b0, opcode: gp_cmd_r.opcode, addr: gp_cmd_r.addr};
        dp_cmd_nxt  = '{go: 1'b0, opcode: dp_cmd_r.opcode, addr: dp_cmd_r.addr};
        wr_en       = 1'b0;
        wr_idx      = HOST_ADDR_I[IDX_MSB:IDX_LSB];
        done        = 1'b0;
        done_data   = GMEM_RDATA_I;
        nr          = sel_req(dp_go ? OWN_DP : OWN_GP, GP_REQ_I, DP_REQ_I);
        cur         = sel_req(own_r, GP_REQ_I, DP_REQ_I);
        unique case (state_r)
            // Host first, then display, then graphics processor.
            S_IDLE: begin
                if (host_start) begin
                    own_nxt = OWN_HOST;
                    if (reg_hit) begin
                        state_nxt = S_REG;
                    end else begin
                        gmem_nxt  = '{1'b1, host_wr, HOST_ADDR_I, HOST_WDATA_I};
                        state_nxt = S_GMEM;
                    end
                end else if (dp_go || gp_go) begin
                    own_nxt = dp_go ? OWN_DP : OWN_GP;
                    if (nr.sys) begin
                        hold_nxt  = 1'b1;
                        state_nxt = S_HOLD;
                    end else begin
                        gmem_nxt  = '{1'b1, nr.we, nr.addr, nr.wdata};
                        state_nxt = S_GMEM;
                    end
                end
            end
            // Register block access; reserved words read back whatever is stored.
            S_REG: begin
                if (host_wr) begin
                    wr_en = 1'b1;
                    if (wr_idx == REG_GP_OPC) begin
                        gp_cmd_nxt = '{1'b1, HOST_WDATA_I, regs_r[REG_GP_ADR]};
                    end
                    if (wr_idx == REG_DP_OPC) begin
                        dp_cmd_nxt = '{1'b1, HOST_WDATA_I, regs_r[REG_DP_ADR]};
                    end
                end else begin
                    rdata_nxt = regs_r[wr_idx];
                end
                ready_n_nxt = 1'b0;
                state_nxt   = S_END;
            end
            S_GMEM: begin
                if (GMEM_ACK_I) begin
                    gmem_nxt.req = 1'b0;
                    if (own_r == OWN_HOST) begin
                        rdata_nxt   = GMEM_RDATA_I;
                        ready_n_nxt = 1'b0;
                        state_nxt   = S_END;
                    end else begin
                        done      = 1'b1;
                        state_nxt = S_IDLE;
                    end
                end
            end
            // Wait for the host to close its cycle so it is not taken twice.
            S_END: begin
                if (!host_start) begin
                    state_nxt = S_IDLE;
                end
            end
            S_HOLD: begin
                if (BUS_GRANT_ACK_I) begin
                    mst_nxt.addr  = cur.addr;
                    mst_nxt.wdata = cur.wdata;
                    mst_nxt.oe_n  = 1'b0;
                    mst_nxt.st_n  = SYNC_MODE_I ? (cur.we ? ST_WRITE : ST_READ) : ST_IDLE;
                    mst_nxt.rd_n  = SYNC_MODE_I || cur.we;
                    mst_nxt.wr_n  = SYNC_MODE_I || !cur.we;
                    state_nxt     = S_MST;
                end
            end
            S_MST: begin
                if (MST_READY_I) begin
                    mst_nxt   = MST_IDLE;
                    hold_nxt  = 1'b0;
                    done      = 1'b1;
                    done_data = MST_RDATA_I;
                    state_nxt = S_REL;
                end
            end
            S_REL: begin
                if (!BUS_GRANT_ACK_I) begin
                    state_nxt = S_IDLE;
                end
            end
            default: begin
                state_nxt = S_IDLE;
            end
        endcase
        // Deliver a finished processor access to its owner.
        if (done && own_r == OWN_DP) begin
            dp_rsp_nxt = '{1'b1, done_data};
        end
        if (done && own_r == OWN_GP) begin
            gp_rsp_nxt = '{1'b1, done_data};
        end
    end
    // Registers of the sequencer; every output comes from here.
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_r   <= S_IDLE;
            own_r     <= OWN_HOST;
            ready_n_r <= 1'b1;
            rdata_r   <= '0;
            hold_r    <= 1'b0;
            gmem_r    <= '0;
            mst_r     <= MST_IDLE;
            gp_rsp_r  <= '0;
            dp_rsp_r  <= '0;
            gp_cmd_r  <= '0;
            dp_cmd_r  <= '0;
        end else begin
            state_r   <= state_nxt;
            own_r     <= own_nxt;
            ready_n_r <= ready_n_nxt;
            rdata_r   <= rdata_nxt;
            hold_r    <= hold_nxt;
            gmem_r    <= gmem_nxt;
            mst_r     <= mst_nxt;
            gp_rsp_r  <= gp_rsp_nxt;
            dp_rsp_r  <= dp_rsp_nxt;
            gp_cmd_r  <= gp_cmd_nxt;
            dp_cmd_r  <= dp_cmd_nxt;
        end
    end
    // Register block storage, written only from the host path.
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            for (int i = 0; i < NREGS; i++) begin
                regs_r[i] <= (i == 0) ? RELOC_RST : REG_RST;
            end
        end else if (wr_en) begin
            regs_r[wr_idx] <= HOST_WDATA_I;
        end
    end
    assign HOST_RDATA_O   = rdata_r;
    assign HOST_READY_N_O = ready_n_r;
    assign GP_RSP_O       = gp_rsp_r;
    assign DP_RSP_O       = dp_rsp_r;
    assign GP_CMD_O       = gp_cmd_r;
    assign DP_CMD_O       = dp_cmd_r;
    assign GMEM_O         = gmem_r;
    assign HOLD_O         = hold_r;
    assign MST_O          = mst_r;
    // ============================================================
    // Assertions
    // ============================================================
    property p_rdy;
        (state_r == S_IDLE && host_start && reg_hit) |-> ##2 !HOST_READY_N_O;
    endproperty
    a_rdy: assert property (p_rdy) else $error("No ready after register access.");
    property p_hold;
        $fell(MST_O.oe_n) |-> $past(HOLD_O);
    endproperty
    a_hold: assert property (p_hold) else $error("Bus driven without hold.");
    property p_grant;
        !MST_O.oe_n |-> (HOLD_O && $past(BUS_GRANT_ACK_I));
    endproperty
    a_grant: assert property (p_grant) else $error("Bus driven without grant.");
    property p_rel;
        (state_r == S_MST && MST_READY_I) |=> (!HOLD_O && MST_O.oe_n);
    endproperty
    a_rel: assert property (p_rel) else $error("Hold kept after transfer.");
    property p_one;
        $onehot0({GP_RSP_O.ack, DP_RSP_O.ack, !HOST_READY_N_O});
    endproperty
    a_one: assert property (p_one) else $error("Two requesters served at once.");
    property p_excl;
        !(GMEM_O.req && !MST_O.oe_n);
    endproperty
    a_excl: assert property (p_excl) else $error("Memory and master overlap.");
    property p_style;
        (!MST_O.oe_n && MST_O.st_n == ST_IDLE) |-> (MST_O.rd_n != MST_O.wr_n);
    endproperty
    a_style: assert property (p_style) else $error("Master cycle lacks a strobe.");
    property p_strobe;
        (state_r == S_IDLE && !SYNC_MODE_I && HOST_RD_N_I && HOST_WR_N_I &&
         !GP_REQ_I.req && !DP_REQ_I.req) |=> state_r == S_IDLE;
    endproperty
    a_strobe: assert property (p_strobe) else $error("Access without strobe.");
    property p_host;
        wr_en |-> (own_r == OWN_HOST);
    endproperty
    a_host: assert property (p_host) else $error("Processor wrote a register.");
    property p_cmd;
        (state_r == S_REG && host_wr && wr_idx == REG_GP_OPC) |=>
            (GP_CMD_O.go && GP_CMD_O.opcode == $past(HOST_WDATA_I));
    endproperty
    a_cmd: assert property (p_cmd) else $error("Opcode write gave no command.");
    c_reg_access: cover property (state_r == S_REG);
    c_host_gmem: cover property (state_r == S_GMEM && own_r == OWN_HOST && GMEM_ACK_I);
    c_master: cover property (state_r == S_MST && MST_READY_I);
    c_dp_cmd: cover property (DP_CMD_O.go);
endmodule

// ===== test/hbi_sysbus_model.sv
// Purpose: System bus owner that grants hold and answers the device's master cycles.
// Assumes: Outputs change on the falling clock edge; wait_i sets the answer delay.
// Notes:   Read data moves every cycle except the one in which a cycle is answered.
`timescale 1ns/1ns
module hbi_sysbus_model
    import hbi_pkg::*;
(
    input  wire logic          clk_i,
    input  wire logic          rst_n_i,
    input  wire logic [3:0]    wait_i,
    input  wire logic          hold_i,
    input  wire hbi_mst_s      mst_i,
    output logic               grant_o,
    output logic               ready_o,
    output logic      [DW-1:0] rdata_o,
    output hbi_mst_s           seen_o
);
    // ============================================================
    // Grant and ready sequencing
    // ============================================================
    logic [3:0] cnt_r;

    // Grant follows hold after wait_i cycles, and each driven cycle is answered likewise.
    always @(negedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            grant_o <= 1'b0;
            ready_o <= 1'b0;
            rdata_o <= 16'hffff;
            cnt_r   <= 4'h0;
            seen_o  <= MST_IDLE;
        end else begin
            ready_o <= 1'b0;
            rdata_o <= ~rdata_o;
            if (!hold_i) begin
                grant_o <= 1'b0;
                cnt_r   <= 4'h0;
            end else if (cnt_r != wait_i && (!grant_o || !mst_i.oe_n)) begin
                cnt_r <= cnt_r + 4'h1;
            end else if (!grant_o) begin
                grant_o <= 1'b1;
                cnt_r   <= 4'h0;
            end else if (!mst_i.oe_n && !ready_o) begin
                ready_o <= 1'b1;
                rdata_o <= mst_i.addr[15:0] ^ 16'h3c3c;
                seen_o  <= mst_i;
                cnt_r   <= 4'h0;
            end
        end
    end
endmodule

// ===== test/tb.sv
// Purpose: Self-checking bench for the host bus interface arbiter.
// Assumes: Inputs are driven and outputs sampled on the falling clock edge.
// Notes:   Graphics memory is a one-cycle responder kept inside the bench.
`timescale 1ns/1ns
`define CHK(nm, e, g) \
    total_checks++; \
    if ((g) !== (e)) begin \
        err_count++; \
        $display("CHECK FAILED %s exp %0h got %0h", nm, e, g); \
    end
module tb
    import hbi_pkg::*;
;
    // ============================================================
    // Stimulus and observed signals
    // ============================================================
    logic          ref_clk = 1'b0;
    logic          nrst = 1'b0;
    logic          sync_mode = 1'b0;
    logic          cs_n = 1'b1;
    logic          mio = 1'b0;
    logic [1:0]    st_n = ST_IDLE;
    logic          rd_n = 1'b1;
    logic          wr_n = 1'b1;
    logic [AW-1:0] addr = '0;
    logic [DW-1:0] wdata = '0;
    logic [DW-1:0] rdata;
    logic          rdy_n;
    hbi_preq_s     gp_req = '0;
    hbi_preq_s     dp_req = '0;
    hbi_prsp_s     gp_rsp;
    hbi_prsp_s     dp_rsp;
    hbi_cmd_s      gp_cmd;
    hbi_cmd_s      dp_cmd;
    hbi_cmd_s      gp_cmd_q;
    hbi_cmd_s      dp_cmd_q;
    hbi_mem_s      gmem;
    logic          gmem_ack = 1'b0;
    logic [DW-1:0] gmem_rdata = '0;
    logic          hold;
    logic          grant;
    hbi_mst_s      mst;
    hbi_mst_s      seen;
    logic          mst_ready;
    logic [DW-1:0] mst_rdata;
    logic [3:0]    wait_v = 4'h0;
    logic [1:0]    first_ack = 2'h0;
    int            err_count = 0;
    int            total_checks = 0;
    int            host_cyc = 0;
    int            gp_go = 0;
    int            dp_go = 0;
    int            bad_drive = 0;
    int            bad_overlap = 0;

    // The clock toggles every half period of 10 ns.
    initial begin
        forever #10 ref_clk = ~ref_clk;
    end

    hbi_arbiter i_hbi_arbiter (
        .REF_CLK_I(ref_clk), .NRST_I(nrst), .SYNC_MODE_I(sync_mode), .HOST_CS_N_I(cs_n),
        .HOST_MIO_I(mio), .HOST_ST_N_I(st_n), .HOST_RD_N_I(rd_n), .HOST_WR_N_I(wr_n),
        .HOST_ADDR_I(addr), .HOST_WDATA_I(wdata), .HOST_RDATA_O(rdata),
        .HOST_READY_N_O(rdy_n), .GP_REQ_I(gp_req), .GP_RSP_O(gp_rsp), .DP_REQ_I(dp_req),
        .DP_RSP_O(dp_rsp), .GP_CMD_O(gp_cmd), .DP_CMD_O(dp_cmd), .GMEM_O(gmem),
        .GMEM_ACK_I(gmem_ack), .GMEM_RDATA_I(gmem_rdata), .HOLD_O(hold),
        .BUS_GRANT_ACK_I(grant), .MST_O(mst), .MST_READY_I(mst_ready), .MST_RDATA_I(mst_rdata)
    );

    hbi_sysbus_model i_hbi_sysbus_model (
        .clk_i(ref_clk), .rst_n_i(nrst), .wait_i(wait_v), .hold_i(hold), .mst_i(mst),
        .grant_o(grant), .ready_o(mst_ready), .rdata_o(mst_rdata), .seen_o(seen)
    );

    // ============================================================
    // Graphics memory responder and bus monitors
    // ============================================================
    // Answers each memory request after one cycle and tallies bus events.
    always @(negedge ref_clk) begin
        gmem_ack = (gmem.req === 1'b1) && !gmem_ack;
        gmem_rdata = gmem.addr[15:0] ^ 16'ha5a5;
        if (mst.oe_n === 1'b0 && grant !== 1'b1) bad_drive++;
        if (mst.oe_n === 1'b0 && gmem.req === 1'b1) bad_overlap++;
        if (gp_cmd.go === 1'b1) begin
            gp_go++;
            gp_cmd_q = gp_cmd;
        end
        if (dp_cmd.go === 1'b1) begin
            dp_go++;
            dp_cmd_q = dp_cmd;
        end
        if (first_ack == 2'h0) first_ack = {dp_rsp.ack === 1'b1, gp_rsp.ack === 1'b1};
    end

    // ============================================================
    // Transfer tasks
    // ============================================================
    // Host slave cycle: select held until ready is seen, then released for a cycle.
    task automatic host_acc(input logic sy, input logic we, input logic sp,
                            input logic [AW-1:0] a, input logic [DW-1:0] d,
                            output logic [DW-1:0] q);
        @(negedge ref_clk);
        sync_mode = sy;
        cs_n = 1'b0;
        mio = sp;
        addr = a;
        wdata = d;
        st_n = sy ? (we ? ST_WRITE : ST_READ) : ST_IDLE;
        rd_n = sy | we;
        wr_n = sy | !we;
        host_cyc = 0;
        while (rdy_n !== 1'b0 && host_cyc < 60) begin
            @(negedge ref_clk);
            host_cyc++;
        end
        `CHK("host ready", 1'b1, host_cyc < 60)
        q = rdata;
        cs_n = 1'b1;
        st_n = ST_IDLE;
        rd_n = 1'b1;
        wr_n = 1'b1;
        @(negedge ref_clk);
        `CHK("ready pulse", 1'b1, rdy_n)
    endtask

    // Processor request held until its acknowledge, then dropped.
    task automatic proc_acc(input logic dp, input hbi_preq_s r, output logic [DW-1:0] q);
        int n;
        @(negedge ref_clk);
        if (dp) dp_req = r;
        else gp_req = r;
        n = 0;
        while ((dp ? dp_rsp.ack : gp_rsp.ack) !== 1'b1 && n < 80) begin
            @(negedge ref_clk);
            n++;
        end
        `CHK("proc ack", 1'b1, n < 80)
        q = dp ? dp_rsp.rdata : gp_rsp.rdata;
        if (dp) dp_req.req = 1'b0;
        else gp_req.req = 1'b0;
    endtask

    // ============================================================
    // Scenarios
    // ============================================================
    // Register block reached through both qualifier styles.
    task automatic t_regs();
        logic [DW-1:0] q;
        host_acc(1'b1, 1'b0, 1'b0, 22'h000000, 16'h0000, q);
        `CHK("reloc reset", RELOC_RST, q)
        `CHK("read cycles", 2, host_cyc)
        host_acc(1'b0, 1'b1, 1'b0, 22'h000006, 16'h1234, q);
        `CHK("write cycles", 2, host_cyc)
        host_acc(1'b0, 1'b1, 1'b0, 22'h00007e, 16'h0000, q);
        host_acc(1'b1, 1'b0, 1'b0, 22'h000006, 16'h0000, q);
        `CHK("reg readback", 16'h1234, q)
        `CHK("no early go", 0, gp_go)
    endtask

    // Address then opcode word for each processor; only the opcode launches.
    task automatic t_cmd();
        logic [DW-1:0] q;
        for (int p = 0; p < 2; p++) begin
            host_acc(1'b0, 1'b1, 1'b0, 22'(4 * p + 6), 16'h00a0 + 16'(p), q);
            host_acc(1'b1, 1'b1, 1'b0, 22'(4 * p + 4), 16'h0017 + 16'(p), q);
        end
        `CHK("gp go", 1, gp_go)
        `CHK("gp cmd", {1'b1, 16'h0017, 16'h00a0}, gp_cmd_q)
        `CHK("dp go", 1, dp_go)
        `CHK("dp cmd", {1'b1, 16'h0018, 16'h00a1}, dp_cmd_q)
    endtask

    // Host accesses outside the block go to graphics memory.
    task automatic t_gmem();
        logic [DW-1:0] q;
        host_acc(1'b0, 1'b0, 1'b0, 22'h000200, 16'h0000, q);
        `CHK("gmem read", 16'h0200 ^ 16'ha5a5, q)
        host_acc(1'b1, 1'b1, 1'b1, 22'h001234, 16'h5a5a, q);
        `CHK("gmem write", {1'b0, 1'b1, 22'h001234, 16'h5a5a}, gmem)
    endtask

    // Both processors ask at once; display wins and never sees the registers.
    task automatic t_arb();
        logic [DW-1:0] qd;
        logic [DW-1:0] qg;
        first_ack = 2'h0;
        fork
            proc_acc(1'b1, '{1'b1, 1'b0, 1'b0, 22'h000006, 16'h0000}, qd);
            proc_acc(1'b0, '{1'b1, 1'b0, 1'b0, 22'h000100, 16'h0000}, qg);
        join
        `CHK("first served", 2'h2, first_ack)
        `CHK("dp gmem data", 16'h0006 ^ 16'ha5a5, qd)
        `CHK("gp gmem data", 16'h0100 ^ 16'ha5a5, qg)
    endtask

    // Master write beside a host memory access, then a slow asynchronous master read.
    task automatic t_master();
        logic [DW-1:0] q;
        logic [DW-1:0] qh;
        sync_mode = 1'b1;
        wait_v = 4'h3;
        fork
            proc_acc(1'b0, '{1'b1, 1'b1, 1'b1, 22'h012340, 16'hbeef}, q);
            host_acc(1'b1, 1'b0, 1'b0, 22'h000300, 16'h0000, qh);
        join
        `CHK("hold released", 1'b0, hold)
        `CHK("mst write", {22'h012340, 16'hbeef, ST_WRITE, 3'b110}, seen)
        `CHK("host beside", 16'h0300 ^ 16'ha5a5, qh)
        sync_mode = 1'b0;
        proc_acc(1'b1, '{1'b1, 1'b1, 1'b0, 22'h004440, 16'h0000}, q);
        `CHK("mst read data", 16'h4440 ^ 16'h3c3c, q)
        `CHK("mst read ctl", {22'h004440, 16'h0000, ST_IDLE, 3'b010}, seen)
        `CHK("drive before grant", 0, bad_drive)
        `CHK("overlap", 0, bad_overlap)
        `CHK("hold after read", 1'b0, hold)
    endtask

    // Block moved to a memory-space base; the old place falls through to memory.
    task automatic t_reloc();
        logic [DW-1:0] q;
        host_acc(1'b0, 1'b1, 1'b0, 22'h000000, 16'hfc03, q);
        host_acc(1'b1, 1'b0, 1'b0, 22'h00000a, 16'h0000, q);
        `CHK("old base", 16'h000a ^ 16'ha5a5, q)
        host_acc(1'b1, 1'b0, 1'b1, 22'h3f008a, 16'h0000, q);
        `CHK("new base", 16'h00a1, q)
        host_acc(1'b0, 1'b0, 1'b0, 22'h3f008a, 16'h0000, q);
        `CHK("wrong space", 16'h008a ^ 16'ha5a5, q)
    endtask

    // ============================================================
    // Sequence, verdict and watchdog
    // ============================================================
    task automatic results();
        if (err_count == 0 && total_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // Reset for 16 cycles, then run every scenario.
    initial begin
        repeat (16) @(negedge ref_clk);
        nrst = 1'b1;
        t_regs();
        t_cmd();
        t_gmem();
        t_arb();
        t_master();
        t_reloc();
        results();
    end

    // The scenarios need well under 2000 cycles, so 20000 means a hang.
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        results();
    end
endmodule
